// ==== core/cis_core.sv ====
// instruction execution core: registers over apb, data memory, flags, skips, progmem port
`timescale 1ns/1ps

module cis_core #(
  parameter int unsigned LOC_W = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire cis_pkg::cis_apb_req_t apb_req,
  output      cis_pkg::cis_apb_rsp_t apb_rsp,
  output      cis_pkg::cis_pm_req_t  pm_req,
  input  wire logic                  pm_ack,
  input  wire logic [15:0]           pm_rdata,
  output      logic [7:0]            clock_rate,
  output      logic                  break_hit,
  output      logic                  return_taken
);
  import cis_pkg::*;

  localparam int unsigned WORDS = 1 << LOC_W;

  typedef struct packed {
    cis_fsm_t               fsm;
    logic                   ack;
    logic [31:0]            prdata;
    logic                   slverr;
    logic [7:0]             acc;
    logic [7:0]             status;
    logic [7:0]             stack_top_pointer;
    logic [7:0]             data_pointer_high;
    logic [7:0]             data_pointer_low;
    logic [7:0]             clock_rate_register;
    logic [2:0]             ret_page;
    logic [15:0]            fetch_address;
    logic [15:0]            pm_rdata;
    logic                   skip;
    logic                   brk;
    logic                   brkx;
    logic                   ret;
    logic                   pm_adv;
    cis_pm_req_t            pm;
    logic [WORDS-1:0][7:0]  mem;
  } cis_state_t;

  cis_state_t s_r;
  cis_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers; sub gives carry as "no borrow"
  function automatic cis_alu_t alu_add(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    alu_add.res = sum[7:0];
    alu_add.ovf = sum[8];
    alu_add.nib = low[4];
    alu_add.nul = (sum[7:0] == 8'h00);
  endfunction

  function automatic cis_alu_t alu_sub(input logic [7:0] a, input logic [7:0] b,
                                       input logic bin);
    logic [8:0] dif;
    logic [4:0] low;
    dif = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    alu_sub.res = dif[7:0];
    alu_sub.ovf = ~dif[8];
    alu_sub.nib = ~low[4];
    alu_sub.nul = (dif[7:0] == 8'h00);
  endfunction

  function automatic logic in_mem_window(input logic [11:0] a);
    in_mem_window = (a[11:10] == MEM_WIN_SEL);
  endfunction

  function automatic logic reg_known(input logic [11:0] a);
    reg_known = in_mem_window(a) || (a == OFF_CMD) || (a == OFF_ACC) ||
                (a == OFF_STATUS) || (a == OFF_STACK) || (a == OFF_DPTR) ||
                (a == OFF_FETCH) || (a == OFF_CLKRATE) || (a == OFF_EXEC) ||
                (a == OFF_RETPAGE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic             access;
  logic             wr_go;
  logic             exec;
  cis_op_t          op;
  logic             use_imm;
  logic             to_acc;
  logic [2:0]       bit_sel;
  logic [LOC_W-1:0] loc;
  logic [7:0]       imm;
  logic [7:0]       opnd;
  logic [7:0]       src;
  logic [7:0]       stack_next;
  cis_alu_t         sub_r;
  cis_alu_t         add_r;
  cis_alu_t         dn_r;
  cis_alu_t         up_r;

  assign access     = apb_req.psel & apb_req.penable;
  assign wr_go      = access & s_r.ack & apb_req.pwrite;
  assign exec       = wr_go & (apb_req.paddr == OFF_CMD) & (s_r.fsm == FSM_IDLE);
  assign op         = cis_op_t'(apb_req.pwdata[CMD_OP_LSB +: 6]);
  assign use_imm    = apb_req.pwdata[CMD_IMM_BIT];
  assign to_acc     = apb_req.pwdata[CMD_ACC_BIT] | use_imm;
  assign bit_sel    = apb_req.pwdata[CMD_BIT_LSB +: 3];
  assign loc        = apb_req.pwdata[CMD_LOC_LSB +: LOC_W];
  assign imm        = apb_req.pwdata[CMD_LIT_LSB +: 8];
  assign opnd       = s_r.mem[loc];
  assign src        = use_imm ? imm : opnd;
  assign stack_next = s_r.stack_top_pointer + STEP_ONE;
  assign sub_r      = alu_sub(src, s_r.acc, 1'b0);
  assign add_r      = alu_add(s_r.acc, src, 1'b0);
  assign dn_r       = alu_sub(opnd, STEP_ONE, 1'b0);
  assign up_r       = alu_add(opnd, STEP_ONE, 1'b0);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cis_alu_t   r;
    logic [7:0] wval;
    logic       wput;
    r    = sub_r;
    wval = 8'h00;
    wput = 1'b0;
    s_nxt = s_r;
    s_nxt.ret = 1'b0;
    // one wait state so read data leaves a flop
    s_nxt.ack = access & ~s_r.ack;
    if (access & ~s_r.ack) begin
      s_nxt.slverr = ~reg_known(apb_req.paddr);
      s_nxt.prdata = 32'h0000_0000;
      if (in_mem_window(apb_req.paddr)) begin
        s_nxt.prdata[7:0] = s_r.mem[apb_req.paddr[LOC_W+1:2]];
      end else begin
        unique case (apb_req.paddr)
          OFF_ACC:     s_nxt.prdata[7:0] = s_r.acc;
          OFF_STATUS:  s_nxt.prdata[7:0] = s_r.status;
          OFF_STACK:   s_nxt.prdata[7:0] = s_r.stack_top_pointer;
          OFF_DPTR:    s_nxt.prdata[15:0] = {s_r.data_pointer_high, s_r.data_pointer_low};
          OFF_FETCH:   s_nxt.prdata[15:0] = s_r.fetch_address;
          OFF_CLKRATE: s_nxt.prdata[7:0] = s_r.clock_rate_register;
          OFF_RETPAGE: s_nxt.prdata[2:0] = s_r.ret_page;
          OFF_EXEC: begin
            s_nxt.prdata[EX_SKIP]          = s_r.skip;
            s_nxt.prdata[EX_BUSY]          = (s_r.fsm == FSM_WAIT);
            s_nxt.prdata[EX_BRK]           = s_r.brk;
            s_nxt.prdata[EX_BRKX]          = s_r.brkx;
            s_nxt.prdata[EX_RD_LSB +: 16]  = s_r.pm_rdata;
          end
          default:     s_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    // plain register writes; a command write while busy is dropped
    if (wr_go) begin
      if (in_mem_window(apb_req.paddr)) begin
        s_nxt.mem[apb_req.paddr[LOC_W+1:2]] = apb_req.pwdata[7:0];
      end else begin
        unique case (apb_req.paddr)
          OFF_ACC:     s_nxt.acc = apb_req.pwdata[7:0];
          OFF_STATUS:  s_nxt.status = apb_req.pwdata[7:0];
          OFF_STACK:   s_nxt.stack_top_pointer = apb_req.pwdata[7:0];
          OFF_FETCH:   s_nxt.fetch_address = apb_req.pwdata[15:0];
          OFF_RETPAGE: s_nxt.ret_page = apb_req.pwdata[2:0];
          OFF_EXEC: begin
            if (apb_req.pwdata[EX_BRK]) begin
              s_nxt.brk = 1'b0;
            end
            if (apb_req.pwdata[EX_BRKX]) begin
              s_nxt.brkx = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    // a pending skip swallows exactly one command, except the extending break
    if (exec) begin
      if (s_r.skip && (op != OP_BREAK_EXTEND)) begin
        s_nxt.skip = 1'b0;
      end else begin
        s_nxt.skip = 1'b0;
        unique case (op)
          OP_ADD, OP_ADD_OVF: begin
            r = alu_add(s_r.acc, src, (op == OP_ADD_OVF) & s_r.status[ST_OVF]);
            wval = r.res;
            wput = 1'b1;
            s_nxt.status[ST_NULL:ST_OVF] = {r.nul, r.nib, r.ovf};
          end
          OP_SUB, OP_SUB_BORROW: begin
            r = alu_sub(src, s_r.acc, (op == OP_SUB_BORROW) & s_r.status[ST_OVF]);
            wval = r.res;
            wput = 1'b1;
            s_nxt.status[ST_NULL:ST_OVF] = {r.nul, r.nib, r.ovf};
          end
          OP_COMPARE: begin
            s_nxt.status[ST_NULL:ST_OVF] = {sub_r.nul, sub_r.nib, sub_r.ovf};
          end
          OP_CMP_SKIP_EQ:  s_nxt.skip = sub_r.nul;
          OP_CMP_SKIP_NE:  s_nxt.skip = ~sub_r.nul;
          OP_COUNTDOWN, OP_COUNTUP: begin
            r = (op == OP_COUNTUP) ? up_r : dn_r;
            wval = r.res;
            wput = 1'b1;
            s_nxt.status[ST_NULL] = r.nul;
          end
          OP_COUNTDOWN_SKIP_ZERO, OP_COUNTDOWN_SKIP_NONZERO: begin
            wval = dn_r.res;
            wput = 1'b1;
            s_nxt.skip = (op == OP_COUNTDOWN_SKIP_ZERO) ? dn_r.nul : ~dn_r.nul;
          end
          OP_COUNTUP_SKIP_ZERO, OP_COUNTUP_SKIP_NONZERO: begin
            wval = up_r.res;
            wput = 1'b1;
            s_nxt.skip = (op == OP_COUNTUP_SKIP_ZERO) ? up_r.nul : ~up_r.nul;
          end
          OP_BIT_CLEAR:        s_nxt.mem[loc][bit_sel] = 1'b0;
          OP_BIT_FORCE:        s_nxt.mem[loc][bit_sel] = 1'b1;
          OP_SKIP_IF_BIT_HIGH: s_nxt.skip = opnd[bit_sel];
          OP_SKIP_IF_BIT_LOW:  s_nxt.skip = ~opnd[bit_sel];
          OP_STACK_PUSH: begin
            s_nxt.mem[s_r.stack_top_pointer[LOC_W-1:0]] = src;
            s_nxt.stack_top_pointer = s_r.stack_top_pointer - STEP_ONE;
          end
          OP_STACK_POP: begin
            s_nxt.mem[loc] = s_r.mem[stack_next[LOC_W-1:0]];
            s_nxt.stack_top_pointer = stack_next;
          end
          OP_RETURN: begin
            s_nxt.status[ST_PAGE_MSB:ST_PAGE_LSB] = s_r.ret_page;
            s_nxt.ret = 1'b1;
          end
          OP_RETURN_NO_PAGE: s_nxt.ret = 1'b1;
          OP_RETURN_LITERAL: begin
            s_nxt.acc = imm;
            s_nxt.status[ST_PAGE_MSB:ST_PAGE_LSB] = s_r.ret_page;
            s_nxt.ret = 1'b1;
          end
          OP_FLASH_BLOCK_WIPE, OP_PROGMEM_READ, OP_PROGMEM_READ_AUTOADVANCE,
          OP_PROGRAM_RAM_WRITE, OP_PROGMEM_WRITE_AUTOADVANCE: begin
            // core stalls until the memory acknowledges; flags never move
            s_nxt.fsm = FSM_WAIT;
            s_nxt.pm.valid = 1'b1;
            s_nxt.pm.addr = s_r.fetch_address;
            s_nxt.pm.wdata = {8'h00, s_r.acc};
            s_nxt.pm_adv = (op == OP_PROGMEM_READ_AUTOADVANCE) ||
                           (op == OP_PROGMEM_WRITE_AUTOADVANCE);
            unique case (op)
              OP_FLASH_BLOCK_WIPE:  s_nxt.pm.kind = PM_ERASE;
              OP_PROGRAM_RAM_WRITE: s_nxt.pm.kind = PM_WRITE_RAM;
              OP_PROGMEM_WRITE_AUTOADVANCE: s_nxt.pm.kind = PM_WRITE;
              default:              s_nxt.pm.kind = PM_READ;
            endcase
          end
          OP_LOAD_PTR_HIGH: s_nxt.data_pointer_high = imm;
          OP_LOAD_PTR_LOW:  s_nxt.data_pointer_low = imm;
          OP_PAGE_SET:      s_nxt.status[ST_PAGE_MSB:ST_PAGE_LSB] = imm[2:0];
          OP_SPEED_SET:     s_nxt.clock_rate_register = imm;
          OP_BREAK:         s_nxt.brk = 1'b1;
          OP_BREAK_EXTEND: begin
            s_nxt.brk = 1'b1;
            s_nxt.brkx = 1'b1;
            s_nxt.skip = s_r.skip;
          end
          default: begin
          end
        endcase
        if (wput) begin
          if (to_acc) begin
            s_nxt.acc = wval;
          end else begin
            s_nxt.mem[loc] = wval;
          end
        end
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    if ((s_r.fsm == FSM_WAIT) && pm_ack) begin
      s_nxt.fsm = FSM_IDLE;
      s_nxt.pm.valid = 1'b0;
      if (s_r.pm.kind == PM_READ) begin
        s_nxt.pm_rdata = pm_rdata;
      end
      if (s_r.pm_adv) begin
        s_nxt.fetch_address[7:0] = s_r.fetch_address[7:0] + AUTO_STEP;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.fsm <= FSM_IDLE;
      s_r.status <= STATUS_RST;
      s_r.stack_top_pointer <= STACK_RST;
      s_r.clock_rate_register <= CLKRATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp.pready  = s_r.ack;
  assign apb_rsp.prdata  = s_r.prdata;
  assign apb_rsp.pslverr = s_r.slverr;
  assign pm_req          = s_r.pm;
  assign clock_rate      = s_r.clock_rate_register;
  assign break_hit       = s_r.brk;
  assign return_taken    = s_r.ret;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sub_carry_a: assert property ((exec && !s_r.skip && op == OP_SUB) |=>
    s_r.status[ST_OVF] == ($past(src) >= $past(s_r.acc)))
    else $error("subtract carry wrong");
  skip_equal_a: assert property ((exec && !s_r.skip && op == OP_CMP_SKIP_EQ) |=>
    (s_r.skip == ($past(src) == $past(s_r.acc))) && $stable(s_r.status))
    else $error("compare skip wrong");
  countup_skip_a: assert property ((exec && !s_r.skip && op == OP_COUNTUP_SKIP_ZERO) |=>
    s_r.skip == ($past(opnd) == 8'hFF))
    else $error("countup skip wrong");
  bit_skip_a: assert property ((exec && !s_r.skip && op == OP_SKIP_IF_BIT_LOW) |=>
    s_r.skip != $past(opnd[bit_sel]))
    else $error("bit skip wrong");
  push_pointer_a: assert property ((exec && !s_r.skip && op == OP_STACK_PUSH) |=>
    s_r.stack_top_pointer == $past(s_r.stack_top_pointer) - STEP_ONE)
    else $error("push pointer wrong");
  pop_pointer_a: assert property ((exec && !s_r.skip && op == OP_STACK_POP) |=>
    s_r.stack_top_pointer == $past(stack_next))
    else $error("pop pointer wrong");
  fetch_advance_a: assert property ((s_r.fsm == FSM_WAIT && pm_ack && s_r.pm_adv) |=>
    s_r.fetch_address[7:0] == $past(s_r.fetch_address[7:0], 1) + AUTO_STEP)
    else $error("fetch advance wrong");
  wipe_request_a: assert property ((exec && !s_r.skip && op == OP_FLASH_BLOCK_WIPE) |=>
    (pm_req.valid && pm_req.kind == PM_ERASE) until (s_r.fsm == FSM_IDLE))
    else $error("wipe request wrong");
  page_copy_a: assert property ((exec && !s_r.skip && op == OP_PAGE_SET) |=>
    s_r.status[ST_PAGE_MSB:ST_PAGE_LSB] == $past(imm[2:0]))
    else $error("page copy wrong");
  speed_write_a: assert property ((exec && !s_r.skip && op == OP_SPEED_SET) |=>
    clock_rate == $past(imm))
    else $error("speed write wrong");
  skip_keep_a: assert property ((exec && s_r.skip && op == OP_BREAK_EXTEND) |=>
    s_r.skip && break_hit)
    else $error("extended break lost skip");

endmodule

// ==== core/cis_pkg.sv ====
// constants, encodings and carrier structs of the instruction execution block
package cis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] OFF_CMD      = 12'h000;
  localparam logic [11:0] OFF_ACC      = 12'h004;
  localparam logic [11:0] OFF_STATUS   = 12'h008;
  localparam logic [11:0] OFF_STACK    = 12'h00C;
  localparam logic [11:0] OFF_DPTR     = 12'h010;
  localparam logic [11:0] OFF_FETCH    = 12'h014;
  localparam logic [11:0] OFF_CLKRATE  = 12'h018;
  localparam logic [11:0] OFF_EXEC     = 12'h01C;
  localparam logic [11:0] OFF_RETPAGE  = 12'h020;
  localparam logic [1:0]  MEM_WIN_SEL  = 2'h1;

  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_IMM_BIT  = 6;
  localparam int unsigned CMD_ACC_BIT  = 7;
  localparam int unsigned CMD_BIT_LSB  = 8;
  localparam int unsigned CMD_LOC_LSB  = 16;
  localparam int unsigned CMD_LIT_LSB  = 24;

  localparam int unsigned ST_OVF       = 0;
  localparam int unsigned ST_NIB       = 1;
  localparam int unsigned ST_NULL      = 2;
  localparam int unsigned ST_PAGE_LSB  = 5;
  localparam int unsigned ST_PAGE_MSB  = 7;

  localparam int unsigned EX_SKIP      = 0;
  localparam int unsigned EX_BUSY      = 1;
  localparam int unsigned EX_BRK       = 2;
  localparam int unsigned EX_BRKX      = 3;
  localparam int unsigned EX_RD_LSB    = 16;

  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [7:0]  STACK_RST    = 8'hFF;
  localparam logic [7:0]  CLKRATE_RST  = 8'h00;
  localparam logic [7:0]  STEP_ONE     = 8'h01;
  localparam logic [7:0]  AUTO_STEP    = 8'h02;
  localparam int unsigned FLASH_BLOCK_WORDS = 256;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [5:0] {
    OP_NOP                       = 6'h00,
    OP_ADD                       = 6'h01,
    OP_ADD_OVF                   = 6'h02,
    OP_SUB                       = 6'h03,
    OP_SUB_BORROW                = 6'h04,
    OP_COMPARE                   = 6'h05,
    OP_CMP_SKIP_EQ               = 6'h06,
    OP_CMP_SKIP_NE               = 6'h07,
    OP_COUNTDOWN                 = 6'h08,
    OP_COUNTUP                   = 6'h09,
    OP_COUNTDOWN_SKIP_ZERO       = 6'h0A,
    OP_COUNTDOWN_SKIP_NONZERO    = 6'h0B,
    OP_COUNTUP_SKIP_ZERO         = 6'h0C,
    OP_COUNTUP_SKIP_NONZERO      = 6'h0D,
    OP_BIT_CLEAR                 = 6'h0E,
    OP_BIT_FORCE                 = 6'h0F,
    OP_SKIP_IF_BIT_HIGH          = 6'h10,
    OP_SKIP_IF_BIT_LOW           = 6'h11,
    OP_STACK_PUSH                = 6'h12,
    OP_STACK_POP                 = 6'h13,
    OP_RETURN                    = 6'h14,
    OP_RETURN_NO_PAGE            = 6'h15,
    OP_RETURN_LITERAL            = 6'h16,
    OP_FLASH_BLOCK_WIPE          = 6'h17,
    OP_PROGMEM_READ              = 6'h18,
    OP_PROGMEM_READ_AUTOADVANCE  = 6'h19,
    OP_PROGRAM_RAM_WRITE         = 6'h1A,
    OP_PROGMEM_WRITE_AUTOADVANCE = 6'h1B,
    OP_LOAD_PTR_HIGH             = 6'h1C,
    OP_LOAD_PTR_LOW              = 6'h1D,
    OP_PAGE_SET                  = 6'h1E,
    OP_SPEED_SET                 = 6'h1F,
    OP_BREAK                     = 6'h20,
    OP_BREAK_EXTEND              = 6'h21
  } cis_op_t;

  typedef enum logic [1:0] {
    PM_READ      = 2'h0,
    PM_WRITE     = 2'h1,
    PM_WRITE_RAM = 2'h2,
    PM_ERASE     = 2'h3
  } cis_pm_kind_t;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b01,
    FSM_WAIT = 2'b10
  } cis_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cis_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } cis_apb_rsp_t;

  typedef struct packed {
    logic         valid;
    cis_pm_kind_t kind;
    logic [15:0]  addr;
    logic [15:0]  wdata;
  } cis_pm_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic       ovf;
    logic       nib;
    logic       nul;
  } cis_alu_t;

endpackage

// ==== verif/cis_core_tb.sv ====
// self-checking bench for the instruction execution core
`timescale 1ns/1ps
module cis_core_tb;
  import cis_pkg::*;
  logic         core_clk = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic         pm_ack, break_hit, return_taken, ev;
  logic [7:0]   clock_rate;
  logic [15:0]  pm_rdata;
  logic [31:0]  rv;
  cis_apb_req_t apb_req = '0;
  cis_apb_rsp_t apb_rsp;
  cis_pm_req_t  pm_req;
  int           bad_count = 0, checked = 0;
  int           ret_cnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #25 core_clk = ~core_clk;
  // return pulse stands one cycle, so count it rather than poll it
  always @(posedge core_clk) if (return_taken === 1'b1) ret_cnt <= ret_cnt + 1;
  cis_core i_dut (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pm_req(pm_req), .pm_ack(pm_ack), .pm_rdata(pm_rdata), .clock_rate(clock_rate),
    .break_hit(break_hit), .return_taken(return_taken));
  cis_pm_model i_mem (.core_clk(core_clk), .slow(slow), .pm_req(pm_req), .pm_ack(pm_ack),
    .pm_rdata(pm_rdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
    rv = apb_rsp.prdata;
    ev = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rv, exp);
  endtask
  // f = {bit, acc dest, immediate}, x = {immediate, location}; waits out busy
  task automatic op(input cis_op_t o, input logic [4:0] f, input logic [15:0] x);
    xfer(1'b1, OFF_CMD, {x, 5'h00, f, o});
    do xfer(1'b0, OFF_EXEC, 32'h0); while (rv[EX_BUSY] !== 1'b0);
  endtask
  // the nop after the check eats a pending skip so the next test starts clean
  task automatic sk(input logic e);
    chk("skip", {31'h0, rv[EX_SKIP]}, {31'h0, e});
    op(OP_NOP, 5'h00, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    xfer(1'b0, 12'h024, 32'h0);
    chk("pslverr", {31'h0, ev}, 32'h1);
    xfer(1'b1, {MEM_WIN_SEL, 8'h05, 2'h0}, 32'h10);
    xfer(1'b1, OFF_ACC, 32'h03);
    op(OP_SUB, 5'h00, 16'h0005);
    rc({MEM_WIN_SEL, 8'h05, 2'h0}, 32'h0D);
    rc(OFF_STATUS, 32'h01);
    op(OP_SUB, 5'h01, 16'h0300);
    rc(OFF_STATUS, 32'h07);
    op(OP_SUB_BORROW, 5'h02, 16'h0005);
    rc(OFF_ACC, 32'h0C);
    op(OP_CMP_SKIP_EQ, 5'h01, 16'h0C00);
    sk(1'b1);
    op(OP_COUNTDOWN_SKIP_NONZERO, 5'h00, 16'h0005);
    sk(1'b1);
    op(OP_SKIP_IF_BIT_HIGH, 5'h00, 16'h0005);
    sk(1'b0);
    op(OP_STACK_PUSH, 5'h01, 16'h5A00);
    op(OP_STACK_POP, 5'h00, 16'h0009);
    rc({MEM_WIN_SEL, 8'h09, 2'h0}, 32'h5A);
    rc(OFF_STACK, 32'hFF);
    op(OP_PAGE_SET, 5'h01, 16'h0500);
    op(OP_RETURN_NO_PAGE, 5'h00, 16'h0000);
    rc(OFF_STATUS, 32'hA3);
    op(OP_SPEED_SET, 5'h01, 16'h4200);
    chk("clock_rate", {24'h0, clock_rate}, 32'h42);
    slow <= 1'b1;
    xfer(1'b1, OFF_FETCH, 32'h12FE);
    op(OP_PROGMEM_WRITE_AUTOADVANCE, 5'h00, 16'h0000);
    rc(OFF_FETCH, 32'h1200);
    xfer(1'b1, OFF_FETCH, 32'h12FE);
    op(OP_PROGMEM_READ_AUTOADVANCE, 5'h00, 16'h0000);
    rc(OFF_EXEC, 32'h000C_0000);
    op(OP_FLASH_BLOCK_WIPE, 5'h00, 16'h0000);
    op(OP_PROGMEM_READ, 5'h00, 16'h0000);
    rc(OFF_EXEC, 32'hFFFF_0000);
    slow <= 1'b0;
    op(OP_PROGRAM_RAM_WRITE, 5'h00, 16'h0000);
    op(OP_PROGMEM_READ_AUTOADVANCE, 5'h00, 16'h0000);
    rc(OFF_EXEC, 32'h000C_0000);
    rc(OFF_FETCH, 32'h1202);
    xfer(1'b1, OFF_ACC, 32'h82);
    op(OP_ADD, 5'h01, 16'h7E00);
    rc(OFF_ACC, 32'h00);
    rc(OFF_STATUS, 32'hA7);
    op(OP_ADD_OVF, 5'h01, 16'h0100);
    rc(OFF_ACC, 32'h02);
    op(OP_COMPARE, 5'h01, 16'h0200);
    rc(OFF_STATUS, 32'hA7);
    rc(OFF_ACC, 32'h02);
    op(OP_COUNTUP, 5'h02, 16'h0005);
    rc(OFF_ACC, 32'h0D);
    rc(OFF_STATUS, 32'hA3);
    xfer(1'b1, {MEM_WIN_SEL, 8'h06, 2'h0}, 32'hFF);
    op(OP_COUNTUP_SKIP_ZERO, 5'h00, 16'h0006);
    sk(1'b1);
    rc({MEM_WIN_SEL, 8'h06, 2'h0}, 32'h00);
    op(OP_BREAK, 5'h00, 16'h0000);
    chk("break_hit", {31'h0, break_hit}, 32'h1);
    xfer(1'b1, OFF_EXEC, 32'h0C);
    op(OP_BIT_FORCE, 5'h1C, 16'h0006);
    rc({MEM_WIN_SEL, 8'h06, 2'h0}, 32'h80);
    chk("break_hit", {31'h0, break_hit}, 32'h0);
    op(OP_SKIP_IF_BIT_LOW, 5'h1C, 16'h0006);
    sk(1'b0);
    op(OP_BIT_CLEAR, 5'h1C, 16'h0006);
    rc({MEM_WIN_SEL, 8'h06, 2'h0}, 32'h00);
    op(OP_SKIP_IF_BIT_LOW, 5'h1C, 16'h0006);
    op(OP_BREAK_EXTEND, 5'h00, 16'h0000);
    rc(OFF_EXEC, 32'h000C_000D);
    sk(1'b1);
    xfer(1'b1, OFF_RETPAGE, 32'h2);
    op(OP_RETURN_LITERAL, 5'h01, 16'h3300);
    rc(OFF_ACC, 32'h33);
    rc(OFF_STATUS, 32'h43);
    xfer(1'b1, OFF_RETPAGE, 32'h6);
    op(OP_RETURN, 5'h00, 16'h0000);
    rc(OFF_STATUS, 32'hC3);
    chk("returns", ret_cnt, 32'h3);
    op(OP_LOAD_PTR_HIGH, 5'h01, 16'hAB00);
    op(OP_LOAD_PTR_LOW, 5'h01, 16'hCD00);
    rc(OFF_DPTR, 32'hABCD);
    op(OP_STACK_PUSH, 5'h00, 16'h0005);
    rc({MEM_WIN_SEL, 8'hFF, 2'h0}, 32'h0C);
    rc(OFF_STACK, 32'hFE);
    wrap_up;
  end
endmodule

// ==== verif/cis_pm_model.sv ====
// program memory model on the far side of the core's progmem port
`timescale 1ns/1ps
module cis_pm_model (
  input  wire logic                 core_clk,
  input  wire logic                 slow,
  input  wire cis_pkg::cis_pm_req_t pm_req,
  output      logic                 pm_ack,
  output      logic [15:0]          pm_rdata
);
  import cis_pkg::*;
  logic [15:0] mem_r [256];
  logic [1:0]  wait_r;
  // slow mode stalls three cycles; idle data toggles so stale data never looks valid
  always_ff @(posedge core_clk) begin
    pm_ack   <= 1'b0;
    pm_rdata <= ~pm_rdata;
    wait_r   <= (pm_req.valid && !pm_ack) ? wait_r + 2'h1 : 2'h0;
    if (pm_req.valid && !pm_ack && wait_r >= {slow, slow}) begin
      pm_ack   <= 1'b1;
      pm_rdata <= mem_r[pm_req.addr[8:1]];
      if (pm_req.kind == PM_ERASE) begin
        for (int i = 0; i < FLASH_BLOCK_WORDS; i++) mem_r[i] <= 16'hFFFF;
      end else if (pm_req.kind != PM_READ) begin
        mem_r[pm_req.addr[8:1]] <= pm_req.wdata;
      end
    end
  end
endmodule
